//--- shared/brc_pkg.sv
// brc_pkg: register map, field layout and types of the clocked burst read sequencer
// assumes: compiled before core/brc_top.sv and the bench; nothing is imported, names are scoped
package brc_pkg;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [15:0] CTRL_OFFS = 16'h101c;
  localparam logic [15:0] STAT_OFFS = 16'h1020;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------
  // burst timing
  // ----------------------------------------
  // base latency in burst clocks, added to the latency field
  localparam logic [4:0] LAT_BASE = 5'h02;
  localparam logic [3:0] LEN_MAX = 4'ha;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef struct packed {
    logic [3:0] length;
    logic [3:0] latency;
    logic [4:0] rsv;
    logic hold;
    logic sample_edge_select;
    logic burst_mode_enable;
  } brc_ctrl_t;

  typedef struct packed {
    logic [15:0] data;
    logic oe;
  } brc_bus_t;

  typedef enum {ST_IDLE, ST_LAT, ST_DATA} brc_state_t;

endpackage

//--- core/brc_top.sv
// brc_top: clocked burst read output sequencer with its word FIFO and AXI4-Lite registers
// assumes: aclk far faster than the burst clock; pins come in asynchronous and are
// synchronised here; the flash side pushes words into src_* as a valid/ready stream
//
// Functional notes
// - enable low ignores burst clock, no bursts
// - enable high, host reads are clocked bursts
// - edge select 0 samples strobes on rise
// - edge select 1 samples on fall
// - hold 0 keeps each word one clock
// - hold 1 keeps each word two clocks
// - first word after two plus latency clocks
// - hold 0 bursts two-to-length units
// - hold 1 bursts two-to-length-minus-one units
// - unit is byte or word by width
// - width pin low 8-bit, high 16-bit
// - burst clock serves only burst reads
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ps

module brc_fifo #(
  parameter int W = 16,
  parameter int D = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // fill side
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // drain side
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  localparam logic [AW:0] CNT_FULL = (AW+1)'(D);
  logic [W-1:0] mem_reg [D];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0] cnt_reg;
  logic [AW:0] cnt_next;
  logic ready_reg;
  wire push = in_valid & ready_reg;
  wire pop = out_ready & out_valid;
  wire [AW-1:0] wr_inc = (wr_reg == AW'(D - 1)) ? '0 : wr_reg + 1'b1;
  wire [AW-1:0] rd_inc = (rd_reg == AW'(D - 1)) ? '0 : rd_reg + 1'b1;

  assign cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
  assign in_ready = ready_reg;
  assign out_valid = cnt_reg != '0;
  assign out_data = mem_reg[rd_reg];

  // ready is registered so the source never sees a combinational path
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
      ready_reg <= 1'b0;
    end else begin
      if (push) begin
        wr_reg <= wr_inc;
      end
      if (pop) begin
        rd_reg <= rd_inc;
      end
      cnt_reg <= cnt_next;
      ready_reg <= cnt_next != CNT_FULL;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data;
    end
  end
endmodule

module brc_top #(
  parameter int FIFO_DEPTH = 4
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [15:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [15:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // host port pins
  input wire logic burst_clk,
  input wire logic chip_select_n,
  input wire logic read_strobe_n,
  input wire logic bus_width_select,
  output logic [15:0] host_data_o,
  output logic host_data_oe,
  // flash word stream
  input wire logic [15:0] src_data,
  input wire logic src_valid,
  output logic src_ready
);
  // ----------------------------------------
  // pin synchronisers: {clk, cs_n, rd_n, width}
  // ----------------------------------------
  logic [3:0] meta_reg;
  logic [3:0] sync_reg;
  logic clk_prev_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= 4'h6;
      sync_reg <= 4'h6;
      clk_prev_reg <= 1'b0;
    end else begin
      meta_reg <= {burst_clk, chip_select_n, read_strobe_n, bus_width_select};
      sync_reg <= meta_reg;
      clk_prev_reg <= sync_reg[3];
    end
  end

  // ----------------------------------------
  // control register and decode
  // ----------------------------------------
  brc_pkg::brc_ctrl_t ctrl_reg;
  brc_pkg::brc_state_t state_reg, state_next;
  logic [4:0] lat_reg, lat_next;
  logic hold_reg, hold_next;
  logic [16:0] units_reg, units_next;
  brc_pkg::brc_bus_t bus_reg, bus_next;
  logic pop;
  wire [15:0] fifo_data;
  wire fifo_valid;

  wire clk_rise = sync_reg[3] & ~clk_prev_reg;
  wire clk_fall = ~sync_reg[3] & clk_prev_reg;
  wire samp = ctrl_reg.sample_edge_select ? clk_fall : clk_rise;
  wire strobes_on = ~sync_reg[2] & ~sync_reg[1];
  wire wide = sync_reg[0];
  wire [16:0] units_full = 17'h0_0001 << ctrl_reg.length;
  wire [16:0] units_hold = (ctrl_reg.length == 4'h0) ? 17'h0_0001 : (units_full >> 1);
  wire [16:0] units_calc = ctrl_reg.hold ? units_hold : units_full;
  wire [15:0] word = wide ? fifo_data : {8'h00, fifo_data[7:0]};
  wire start = ctrl_reg.burst_mode_enable & samp & strobes_on;

  // ----------------------------------------
  // burst sequencer, stepped on sampling edges of the burst clock
  // ----------------------------------------
  // the pin path costs about three aclk periods, well inside half a burst clock
  always_comb begin
    state_next = state_reg;
    lat_next = lat_reg;
    hold_next = hold_reg;
    units_next = units_reg;
    bus_next = bus_reg;
    pop = 1'b0;
    case (state_reg)
      brc_pkg::ST_IDLE: begin
        // with enable low the clock pin is never looked at
        if (start) begin
          lat_next = brc_pkg::LAT_BASE + {1'b0, ctrl_reg.latency};
          units_next = units_calc;
          state_next = brc_pkg::ST_LAT;
        end
      end
      brc_pkg::ST_LAT: begin
        if (samp && !strobes_on) begin
          state_next = brc_pkg::ST_IDLE;
        end else if (samp && lat_reg == 5'h02) begin
          // driven one edge early so the word already stands at the latch edge
          bus_next = '{data: word, oe: 1'b1};
          pop = fifo_valid;
          hold_next = ctrl_reg.hold;
          state_next = brc_pkg::ST_DATA;
        end else if (samp) begin
          lat_next = lat_reg - 5'h01;
        end
      end
      brc_pkg::ST_DATA: begin
        if (samp && (!strobes_on || units_reg == 17'h0_0001) && !hold_reg) begin
          bus_next = '{data: 16'h0000, oe: 1'b0};
          state_next = brc_pkg::ST_IDLE;
        end else if (samp && !strobes_on) begin
          bus_next = '{data: 16'h0000, oe: 1'b0};
          state_next = brc_pkg::ST_IDLE;
        end else if (samp && hold_reg) begin
          hold_next = 1'b0;
        end else if (samp) begin
          bus_next.data = word;
          pop = fifo_valid;
          hold_next = ctrl_reg.hold;
          units_next = units_reg - 17'h0_0001;
        end
      end
      default: begin
        state_next = brc_pkg::ST_IDLE;
      end
    endcase
    if (!ctrl_reg.burst_mode_enable) begin
      state_next = brc_pkg::ST_IDLE;
      bus_next = '{data: 16'h0000, oe: 1'b0};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= brc_pkg::ST_IDLE;
      lat_reg <= 5'h00;
      hold_reg <= 1'b0;
      units_reg <= 17'h0_0000;
      bus_reg <= '0;
    end else begin
      state_reg <= state_next;
      lat_reg <= lat_next;
      hold_reg <= hold_next;
      units_reg <= units_next;
      bus_reg <= bus_next;
    end
  end

  assign host_data_o = bus_reg.data;
  assign host_data_oe = bus_reg.oe;

  // underrun drives the stale word left in the next buffer slot; the flash side must keep ahead of the host
  brc_fifo #(.W(16), .D(FIFO_DEPTH)) u_fifo (
    .clk(aclk),
    .rst_n(aresetn),
    .in_data(src_data),
    .in_valid(src_valid),
    .in_ready(src_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(pop)
  );

  // ----------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------
  logic aw_have_reg, w_have_reg;
  logic [15:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [31:0] rdata_reg;
  wire aw_take = s_axi_awvalid & awready_reg;
  wire w_take = s_axi_wvalid & wready_reg;
  wire wr_go = aw_have_reg & w_have_reg & ~bvalid_reg;
  wire wr_ctrl = awaddr_reg == brc_pkg::CTRL_OFFS;
  wire wr_stat = awaddr_reg == brc_pkg::STAT_OFFS;
  wire ar_take = s_axi_arvalid & arready_reg;
  wire rd_ctrl = s_axi_araddr == brc_pkg::CTRL_OFFS;
  wire rd_stat = s_axi_araddr == brc_pkg::STAT_OFFS;
  wire [31:0] ctrl_view = {16'h0000, ctrl_reg.length, ctrl_reg.latency, 5'h00, ctrl_reg[2:0]};
  wire [31:0] stat_view = {30'h0000_0000, wide, state_reg != brc_pkg::ST_IDLE};
  wire [31:0] rd_word = rd_ctrl ? ctrl_view : (rd_stat ? stat_view : 32'h0000_0000);
  wire [1:0] rd_resp = (rd_ctrl || rd_stat) ? brc_pkg::RESP_OKAY : brc_pkg::RESP_SLVERR;
  wire [1:0] wr_resp = (wr_ctrl || wr_stat) ? brc_pkg::RESP_OKAY : brc_pkg::RESP_SLVERR;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'h0;
      awaddr_reg <= 16'h0000;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end else begin
      if (aw_take) begin
        awaddr_reg <= s_axi_awaddr;
        aw_have_reg <= 1'b1;
        awready_reg <= 1'b0;
      end
      if (w_take) begin
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
        w_have_reg <= 1'b1;
        wready_reg <= 1'b0;
      end
      if (wr_go) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_resp;
      end
      if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg <= 1'b1;
      end
    end
  end

  // software must keep length at ten or below; larger values are stored as written
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= brc_pkg::CTRL_RESET;
    end else if (wr_go && wr_ctrl) begin
      if (wstrb_reg[0]) begin
        ctrl_reg[7:0] <= {5'h00, wdata_reg[2:0]};
      end
      if (wstrb_reg[1]) begin
        ctrl_reg[15:8] <= wdata_reg[15:8];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= 2'h0;
    end else if (ar_take) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_word;
      rresp_reg <= rd_resp;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_DISABLED_QUIET: assert property (!ctrl_reg.burst_mode_enable |=> !host_data_oe && state_reg == brc_pkg::ST_IDLE) else $error("burst active while disabled");
  AST_RISE_ONLY: assert property (state_reg == brc_pkg::ST_IDLE && !ctrl_reg.sample_edge_select && !clk_rise |=> state_reg == brc_pkg::ST_IDLE) else $error("burst started off a rising edge");
  AST_FALL_ONLY: assert property (state_reg == brc_pkg::ST_IDLE && ctrl_reg.sample_edge_select && !clk_fall |=> state_reg == brc_pkg::ST_IDLE) else $error("burst started off a falling edge");
  AST_LAT_LOAD: assert property (state_reg == brc_pkg::ST_IDLE && start |=> state_reg == brc_pkg::ST_LAT && lat_reg == 5'($past(ctrl_reg.latency)) + 5'h02) else $error("latency load wrong");
  AST_LAT_STEP: assert property (state_reg == brc_pkg::ST_LAT && samp && strobes_on && lat_reg > 5'h02 && ctrl_reg.burst_mode_enable |=> lat_reg == $past(lat_reg) - 5'h01) else $error("latency count skipped");
  AST_UNITS_LOAD: assert property (state_reg == brc_pkg::ST_IDLE && start |=> units_reg == $past(units_calc)) else $error("burst length wrong");
  AST_HOLD_TWO: assert property (state_reg == brc_pkg::ST_DATA && hold_reg && samp && strobes_on && ctrl_reg.burst_mode_enable |=> $stable(host_data_o) && host_data_oe && !hold_reg) else $error("held word changed");
  AST_HOLD_ONE: assert property (state_reg == brc_pkg::ST_DATA && !hold_reg && samp && strobes_on && units_reg > 17'h0_0001 && ctrl_reg.burst_mode_enable |=> units_reg == $past(units_reg) - 17'h0_0001 && hold_reg == $past(ctrl_reg.hold)) else $error("word not advanced");
  AST_LAST_RELEASE: assert property (state_reg == brc_pkg::ST_DATA && !hold_reg && samp && units_reg == 17'h0_0001 |=> !host_data_oe ##1 !host_data_oe) else $error("bus kept after last unit");
  AST_BYTE_LANE: assert property (state_reg == brc_pkg::ST_LAT && samp && strobes_on && lat_reg == 5'h02 && !wide && ctrl_reg.burst_mode_enable |=> host_data_oe && host_data_o[15:8] == 8'h00) else $error("upper byte driven in byte mode");
  AST_RESET_ZERO: assert property ($rose(aresetn) |-> ctrl_reg == 16'h0000 && state_reg == brc_pkg::ST_IDLE) else $error("control not cleared by reset");

  COV_HOLD_BURST: cover property (state_reg == brc_pkg::ST_DATA && hold_reg ##1 state_reg == brc_pkg::ST_IDLE);
  COV_FALL_START: cover property (ctrl_reg.sample_edge_select && state_reg == brc_pkg::ST_IDLE && start);
  COV_ABORT: cover property (state_reg == brc_pkg::ST_DATA && samp && !strobes_on);
  COV_WRITE: cover property (bvalid_reg && s_axi_bready && bresp_reg == brc_pkg::RESP_OKAY);
endmodule

//--- tb/brc_host_model.sv
// brc_host_model: host side that reads clocked bursts over the burst clock and strobe pins
// assumes: the bench sets ncyc and fall_sel, then pulses go; times are in ns
`timescale 1ns/1ps

module brc_host_model (
  // bench control
  input wire logic go,
  input wire logic fall_sel,
  input wire logic [5:0] ncyc,
  // device pins
  input wire logic [15:0] host_data_o,
  input wire logic host_data_oe,
  output logic burst_clk,
  output logic chip_select_n,
  output logic read_strobe_n,
  // what the host latched at each sampling edge
  output logic done,
  output brc_pkg::brc_bus_t log_q [32]
);
  // --------------------------------
  // frame
  // --------------------------------
  // the clock stands still between frames, as a real host would leave it
  initial begin
    burst_clk = 1'b0;
    chip_select_n = 1'b1;
    read_strobe_n = 1'b1;
    done = 1'b1;
  end

  // ncyc sampling edges with strobes low, then two with strobes high to close the frame
  always @(posedge go) begin
    done = 1'b0;
    // odd offset keeps every pin change clear of an aclk edge
    #56;
    chip_select_n = 1'b0;
    read_strobe_n = 1'b0;
    for (int i = 0; i < ncyc + 2; i++) begin
      // strobes move a quarter period before the rise, away from either sampling edge
      #50;
      if (i == ncyc) begin
        chip_select_n = 1'b1;
        read_strobe_n = 1'b1;
      end
      #50 burst_clk = 1'b1;
      if (!fall_sel) log_q[i] = '{host_data_o, host_data_oe};
      #100 burst_clk = 1'b0;
      if (fall_sel) log_q[i] = '{host_data_o, host_data_oe};
    end
    done = 1'b1;
  end
endmodule

//--- tb/brc_top_tb.sv
// brc_top_tb: self-checking bench for the burst read sequencer, its registers and word buffer
// assumes: package and design compiled first; brc_host_model drives the burst pins
`timescale 1ns/1ps

module brc_top_tb;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, src_valid, go, fs, bw;
  logic awready, wready, bvalid, arready, rvalid, src_ready, burst_clk, cs_n, rs_n, oe, done;
  logic [15:0] awaddr, araddr, src_data, hdata;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [5:0] nc_r;
  brc_pkg::brc_bus_t log_q [32];
  int errors, check_count;

  brc_top #(.FIFO_DEPTH(4)) uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .burst_clk(burst_clk), .chip_select_n(cs_n), .read_strobe_n(rs_n), .bus_width_select(bw),
    .host_data_o(hdata), .host_data_oe(oe), .src_data(src_data), .src_valid(src_valid),
    .src_ready(src_ready));

  brc_host_model host (.go(go), .fall_sel(fs), .ncyc(nc_r), .host_data_o(hdata), .host_data_oe(oe),
    .burst_clk(burst_clk), .chip_select_n(cs_n), .read_strobe_n(rs_n), .done(done), .log_q(log_q));

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  // --------------------------------
  // bus tasks
  // --------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic axi_wr(input logic [15:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic push(input logic [15:0] w);
    @(posedge aclk);
    src_data <= w;
    src_valid <= 1'b1;
    do @(posedge aclk); while (src_ready !== 1'b1);
    src_valid <= 1'b0;
  endtask

  // loads u words, runs one frame of nc strobed edges and compares every latched edge but edge nc of a cut-short burst
  task automatic burst(input logic [15:0] c, input int u, input int nc, input logic [15:0] m);
    logic [1:0] r;
    logic [15:0] base;
    logic ex;
    int lat, h, n;
    lat = c[11:8];
    h = c[2];
    n = 2 + lat + u * (1 + h);
    base = c ^ 16'hc35a;
    axi_wr(brc_pkg::CTRL_OFFS, {16'h0000, c}, r);
    for (int k = 0; k < u; k++) push(16'(base + k));
    // ready falls at the edge that takes the last word, so a full buffer is seen one edge later
    @(posedge aclk);
    if (u == 4) chk({31'h0, src_ready}, 32'h0000_0000);
    nc_r <= nc[5:0];
    fs <= c[1];
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    wait (done === 1'b1);
    for (int k = 0; k <= nc + 1; k++) begin
      if (k == nc && nc < n) continue;
      ex = c[0] && k >= 2 + lat && k < n && k < nc;
      chk(32'(log_q[k]), 32'({ex ? 16'(base + (k - 2 - lat) / (1 + h)) & m : 16'h0000, ex}));
    end
  endtask

  // --------------------------------
  // scenarios
  // --------------------------------
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(brc_pkg::CTRL_OFFS, d, r);
    chk(d, 32'h0000_0000);
    axi_wr(brc_pkg::CTRL_OFFS, 32'h0000_afff, r);
    chk({30'h0, r}, 32'h0000_0000);
    axi_rd(brc_pkg::CTRL_OFFS, d, r);
    chk(d, 32'h0000_af07);
    axi_wr(16'h1000, 32'h0000_ffff, r);
    chk({30'h0, r}, 32'h0000_0002);
    axi_rd(16'h1000, d, r);
    chk({d[29:0], r}, 32'h0000_0002);
    axi_rd(brc_pkg::STAT_OFFS, d, r);
    chk(d, 32'h0000_0002);
    $display("test regs done");
  endtask

  task automatic t_rise;
    burst(16'h1001, 2, 4, 16'hffff);
    $display("test rising done");
  endtask

  task automatic t_fall;
    burst(16'h2207, 2, 8, 16'hffff);
    $display("test falling hold done");
  endtask

  task automatic t_byte;
    bw <= 1'b0;
    repeat (4) @(posedge aclk);
    burst(16'h2101, 4, 7, 16'h00ff);
    bw <= 1'b1;
    $display("test byte done");
  endtask

  task automatic t_abort;
    burst(16'h2001, 4, 3, 16'hffff);
    $display("test abort done");
  endtask

  task automatic t_off;
    burst(16'h1000, 0, 6, 16'hffff);
    $display("test disabled done");
  endtask

  // --------------------------------
  // run control
  // --------------------------------
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, src_valid, go, fs} = '0;
    {awaddr, araddr, src_data, wdata, nc_r} = '0;
    wstrb = 4'hf;
    bw = 1'b1;
    errors = 0;
    check_count = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_rise();
    t_fall();
    t_byte();
    t_abort();
    t_off();
    end_of_test();
  end

  // every frame lasts a few microseconds, so this limit only trips on a hang
  initial begin
    #200_000;
    errors++;
    $display("[ERR] %0t watchdog expired", $time);
    end_of_test();
  end
endmodule
